// [dv/fmpm_tb.sv]
// Self-checking bench for the power management register set
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic wake_event = 1'b0;
  logic [31:0] cfg_rdata;
  logic cfg_ack;
  logic wake_out;
  fmpm_pkg::fmpm_power_e power_level;
  logic func_reset;
  logic cold_state_wake_capable;
  int fail_count = 0;
  int n_compared = 0;

  fmpm_regs_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .wake_event(wake_event), .wake_out(wake_out), .power_level(power_level), .func_reset(func_reset),
    .cold_state_wake_capable(cold_state_wake_capable));

  always #5 sys_clk = ~sys_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One request cycle, answer sampled one cycle later
  task automatic acc(input logic rd, input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q);
    @(negedge sys_clk);
    cfg_rd = rd;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    check("cfg_ack", {31'h0, cfg_ack}, 32'h00000001);
    q = cfg_rdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    acc(1'b1, 1'b0, a, 4'hF, 32'h0, q);
    check(name, q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b0, 1'b1, a, be, d, q);
  endtask

  task automatic pulse_wake();
    @(negedge sys_clk);
    wake_event = 1'b1;
    @(negedge sys_clk);
    wake_event = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic t_reset_values();
    rd(8'h46, 32'h7E020000, "caps");
    rd(8'h48, 32'h00000000, "csr");
    wr(8'h48, 4'hF, 32'hFFFF7FFC);
    rd(8'h48, 32'h00000100, "csr ro bits");
    wr(8'h48, 4'h2, 32'h00000000);
    rd(8'h60, 32'h00000000, "unmapped");
  endtask

  task automatic t_cold_wake();
    wr(8'h4C, 4'h1, 32'h00000010);
    check("cold flag", {31'h0, cold_state_wake_capable}, 32'h1);
    rd(8'h46, 32'hFE420000, "caps cold");
    rd(8'h4C, 32'h00000010, "genctl");
    wr(8'h4C, 4'h1, 32'h00000000);
    rd(8'h46, 32'h7E020000, "caps warm");
  endtask

  task automatic t_levels();
    for (int i = 0; i < 4; i++) begin
      wr(8'h48, 4'h1, i);
      check("level port", {30'h0, power_level}, i);
      rd(8'h48, i, "level read");
    end
    wr(8'h48, 4'h2, 32'h00000002);
    check("level no be0", {30'h0, power_level}, 32'h3);
  endtask

  task automatic t_wake();
    pulse_wake();
    check("wake off", {31'h0, wake_out}, 32'h0);
    rd(8'h48, 32'h00008003, "status set");
    wr(8'h48, 4'h2, 32'h00000100);
    @(negedge sys_clk);
    check("wake on", {31'h0, wake_out}, 32'h1);
    wr(8'h48, 4'h1, 32'h00000000);
    check("internal reset", {31'h0, func_reset}, 32'h1);
    rd(8'h48, 32'h00008100, "csr kept");
    wr(8'h48, 4'h2, 32'h00008100);
    @(negedge sys_clk);
    check("wake cleared", {31'h0, wake_out}, 32'h0);
    rd(8'h48, 32'h00000100, "status clear");
    wr(8'h48, 4'h1, 32'h00000002);
  endtask

  task automatic t_global_reset();
    pulse_wake();
    @(negedge sys_clk);
    arst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    rd(8'h48, 32'h00000000, "csr after reset");
    check("wake after reset", {31'h0, wake_out}, 32'h0);
  endtask

  initial begin
    #100us;
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset_values();
    t_cold_wake();
    t_levels();
    t_wake();
    t_global_reset();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire

// [src/fmpm_pkg.sv]
// Types shared by the power management register set
`default_nettype none
package fmpm_pkg;
  typedef enum logic [1:0] {
    FMPM_D0,
    FMPM_D1,
    FMPM_D2,
    FMPM_D3HOT
  } fmpm_power_e;
endpackage
`default_nettype wire

// [src/fmpm_power_ctl.sv]
// Power level holder and internal reset pulse on D3hot to D0
`default_nettype none
module fmpm_power_ctl (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic level_wr,
  input wire logic [1:0] level_val,
  output fmpm_pkg::fmpm_power_e power_level,
  output logic func_reset
);

  fmpm_pkg::fmpm_power_e next_level;

  always_comb begin
    next_level = fmpm_pkg::fmpm_power_e'(level_val);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_level <= fmpm_pkg::FMPM_D0;
    end else if (level_wr) begin
      power_level <= next_level;
    end
  end

  // Function reset leaves the register set untouched
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      func_reset <= 1'b0;
    end else begin
      func_reset <= level_wr && power_level == fmpm_pkg::FMPM_D3HOT && next_level == fmpm_pkg::FMPM_D0;
    end
  end

endmodule // fmpm_power_ctl
`default_nettype wire

// [src/fmpm_regs.svh]
// Register map constants for the flash media power management register set
// Function
// - Capability bit 15 mirrors the cold wake bit written in general control bit 4.
// - Wake-source state field, capability bits 14 to 11, reads all ones.
// - Capability bit 10 always reads one: second sleep state supported.
// - Capability bit 9 always reads one: first sleep state supported.
// - Auxiliary current bits 8 to 6 read 000b without cold wake, else 001b.
// - Capability bit 5 reads zero: no special initialization needed.
// - Reserved capability bit 4 always reads zero.
// - Capability bit 3 reads zero: wake needs no bus clock.
// - Capability bits 2 to 0 read 010b, revision 1.1 register layout.
// - Control and status survive the internal reset on leaving D3hot for D0.
// - Control bit 15 is a wake status flag set by hardware, cleared by software.
// - Data scale and data select fields, bits 14 to 9, read zero.
// - Bit 8 is a writable wake enable; clear means no wake output.
// - Control reserved bits 7 to 2 read zero.
// - Power level bits 1 to 0 encode D0, D1, D2, D3hot as 00 to 11.
// - Software writes the power level; the device adopts and reports it.
// - Of the resets, only global reset clears wake status, wake enable and power level.
// - Bridge support extension byte is read-only zero.
// - Power management data byte is read-only zero.
// - Software sets or clears the cold wake flag through general control bit 4.
`ifndef FMPM_REGS_SVH
`define FMPM_REGS_SVH

`define FMPM_OFS_CAPID 8'h44
`define FMPM_OFS_CAPS 8'h46
`define FMPM_OFS_CSR 8'h48
`define FMPM_OFS_BRIDGE 8'h4A
`define FMPM_OFS_DATA 8'h4B
`define FMPM_OFS_GENCTL 8'h4C

`define FMPM_CAPS_RESET 16'h7E02
`define FMPM_CSR_RESET 16'h0000
`define FMPM_BRIDGE_VALUE 8'h00
`define FMPM_DATA_VALUE 8'h00

`define FMPM_CAP_COLD_BIT 15
`define FMPM_CAP_WAKE_MASK 4'hF
`define FMPM_CAP_AUX_OFF 3'h0
`define FMPM_CAP_AUX_55MA 3'h1
`define FMPM_CAP_REVISION 3'h2

`define FMPM_CSR_STAT_BIT 15
`define FMPM_CSR_EN_BIT 8
`define FMPM_CSR_LEVEL_LSB 0
`define FMPM_GENCTL_COLD_BIT 4
`define FMPM_GENCTL_RESET 1'b0

`endif

// [src/fmpm_regs_top.sv]
// Power management capability register set on the configuration port
`include "fmpm_regs.svh"
`default_nettype none
module fmpm_regs_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic wake_event,
  output logic wake_out,
  output fmpm_pkg::fmpm_power_e power_level,
  output logic func_reset,
  output logic cold_state_wake_capable
);

  // Dword decode of a byte offset
  function automatic logic dw_hit(input logic [7:0] addr, input logic [7:0] ofs);
    dw_hit = addr[7:2] == ofs[7:2];
  endfunction

  // Capability word from the cold wake flag
  function automatic logic [15:0] build_caps(input logic cold);
    logic [2:0] aux;
    aux = cold ? `FMPM_CAP_AUX_55MA : `FMPM_CAP_AUX_OFF;
    build_caps = {cold,
                  `FMPM_CAP_WAKE_MASK,
                  1'b1,
                  1'b1,
                  aux,
                  1'b0,
                  1'b0,
                  1'b0,
                  `FMPM_CAP_REVISION};
  endfunction

  logic hit_capid;
  logic hit_csr;
  logic hit_genctl;
  logic wr_csr_hi;
  logic wr_csr_lo;
  logic wr_genctl;
  logic wake_status;
  logic wake_enable;
  logic [15:0] caps;
  logic [15:0] csr;
  logic [31:0] next_rdata;

  assign hit_capid = dw_hit(cfg_addr, `FMPM_OFS_CAPID);
  assign hit_csr = dw_hit(cfg_addr, `FMPM_OFS_CSR);
  assign hit_genctl = dw_hit(cfg_addr, `FMPM_OFS_GENCTL);
  assign wr_csr_hi = cfg_wr && hit_csr && cfg_be[1];
  assign wr_csr_lo = cfg_wr && hit_csr && cfg_be[0];
  assign wr_genctl = cfg_wr && hit_genctl && cfg_be[0];

  // Cold wake configuration, global reset only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cold_state_wake_capable <= `FMPM_GENCTL_RESET;
    end else if (wr_genctl) begin
      cold_state_wake_capable <= cfg_wdata[`FMPM_GENCTL_COLD_BIT];
    end
  end

  fmpm_wake_ctl u_wake (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wake_event(wake_event),
    .status_clr(wr_csr_hi && cfg_wdata[`FMPM_CSR_STAT_BIT]),
    .enable_wr(wr_csr_hi),
    .enable_val(cfg_wdata[`FMPM_CSR_EN_BIT]),
    .wake_status(wake_status),
    .wake_enable(wake_enable),
    .wake_out(wake_out)
  );

  fmpm_power_ctl u_power (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .level_wr(wr_csr_lo),
    .level_val(cfg_wdata[1:0]),
    .power_level(power_level),
    .func_reset(func_reset)
  );

  assign caps = build_caps(cold_state_wake_capable);
  // Data scale, data select and reserved bits are zero
  assign csr = {wake_status, 6'h00, wake_enable, 6'h00, power_level};

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_capid) begin
      next_rdata = {caps, 16'h0000};
    end else if (hit_csr) begin
      next_rdata = {`FMPM_DATA_VALUE, `FMPM_BRIDGE_VALUE, csr};
    end else if (hit_genctl) begin
      next_rdata = 32'h0000_0000;
      next_rdata[`FMPM_GENCTL_COLD_BIT] = cold_state_wake_capable;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_rd | cfg_wr;
    end
  end

  // Helper state for checks
  logic rd_caps_q;
  logic rd_csr_q;
  logic rd_genctl_q;
  logic cold_q;
  logic status_q;
  logic enable_q;
  logic [1:0] level_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_caps_q <= 1'b0;
      rd_csr_q <= 1'b0;
      rd_genctl_q <= 1'b0;
      cold_q <= 1'b0;
      status_q <= 1'b0;
      enable_q <= 1'b0;
      level_q <= 2'h0;
    end else begin
      rd_caps_q <= cfg_rd && hit_capid;
      rd_csr_q <= cfg_rd && hit_csr;
      rd_genctl_q <= cfg_rd && hit_genctl;
      cold_q <= cold_state_wake_capable;
      status_q <= wake_status;
      enable_q <= wake_enable;
      level_q <= power_level;
    end
  end

  property p_caps_cold;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_caps_q |-> cfg_rdata[16 + `FMPM_CAP_COLD_BIT] == cold_q;
  endproperty
  a_caps_cold: assert property (p_caps_cold) else $error("cold wake capability bit wrong");

  property p_caps_fixed;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_caps_q |-> cfg_rdata[30:25] == 6'h3F && cfg_rdata[21:19] == 3'h0;
  endproperty
  a_caps_fixed: assert property (p_caps_fixed) else $error("fixed capability bits wrong");

  property p_caps_rev;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_caps_q |-> cfg_rdata[18:16] == 3'h2;
  endproperty
  a_caps_rev: assert property (p_caps_rev) else $error("revision field wrong");

  property p_caps_aux;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_caps_q |-> cfg_rdata[24:22] == (cold_q ? 3'h1 : 3'h0);
  endproperty
  a_caps_aux: assert property (p_caps_aux) else $error("aux current field wrong");

  property p_csr_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_csr_q |-> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[14:9] == 6'h00 && cfg_rdata[7:2] == 6'h00;
  endproperty
  a_csr_zero: assert property (p_csr_zero) else $error("zero fields of control word set");

  property p_status_set;
    @(posedge sys_clk) disable iff (!arst_n)
    wake_event |=> wake_status;
  endproperty
  a_status_set: assert property (p_status_set) else $error("wake event lost");

  property p_no_wake_disabled;
    @(posedge sys_clk) disable iff (!arst_n)
    !wake_enable |=> !wake_out;
  endproperty
  a_no_wake_disabled: assert property (p_no_wake_disabled) else $error("wake while disabled");

  property p_wake_cause;
    @(posedge sys_clk) disable iff (!arst_n)
    wake_status && wake_enable |=> wake_out;
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake output missing");

  property p_level_write;
    @(posedge sys_clk) disable iff (!arst_n)
    wr_csr_lo |=> power_level == $past(cfg_wdata[1:0]);
  endproperty
  a_level_write: assert property (p_level_write) else $error("power level not adopted");

  property p_func_reset_keeps;
    @(posedge sys_clk) disable iff (!arst_n)
    func_reset && !$past(wr_csr_hi) |-> $stable(wake_enable) && power_level == fmpm_pkg::FMPM_D0;
  endproperty
  a_func_reset_keeps: assert property (p_func_reset_keeps) else $error("state lost on function reset");

  property p_caps_wake_mask;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_caps_q |-> cfg_rdata[30:27] == 4'hF;
  endproperty
  a_caps_wake_mask: assert property (p_caps_wake_mask) else $error("wake source mask wrong");

  property p_caps_d_states;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_caps_q |-> cfg_rdata[26:25] == 2'h3;
  endproperty
  a_caps_d_states: assert property (p_caps_d_states) else $error("sleep state support bits wrong");

  property p_caps_dsi;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_caps_q |-> cfg_rdata[21:20] == 2'h0;
  endproperty
  a_caps_dsi: assert property (p_caps_dsi) else $error("init or reserved capability bit set");

  property p_caps_nobusclk;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_caps_q |-> cfg_rdata[19] == 1'b0;
  endproperty
  a_caps_nobusclk: assert property (p_caps_nobusclk) else $error("bus clock bit set");

  property p_csr_status;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_csr_q |-> cfg_rdata[`FMPM_CSR_STAT_BIT] == status_q;
  endproperty
  a_csr_status: assert property (p_csr_status) else $error("status bit read wrong");

  property p_csr_enable;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_csr_q |-> cfg_rdata[`FMPM_CSR_EN_BIT] == enable_q;
  endproperty
  a_csr_enable: assert property (p_csr_enable) else $error("enable bit read wrong");

  property p_csr_level;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_csr_q |-> cfg_rdata[1:0] == level_q;
  endproperty
  a_csr_level: assert property (p_csr_level) else $error("power level read wrong");

  property p_csr_rsvd;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_csr_q |-> cfg_rdata[7:2] == 6'h00;
  endproperty
  a_csr_rsvd: assert property (p_csr_rsvd) else $error("reserved control bits set");

  property p_bridge_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_csr_q |-> cfg_rdata[23:16] == 8'h00;
  endproperty
  a_bridge_zero: assert property (p_bridge_zero) else $error("bridge byte not zero");

  property p_data_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_csr_q |-> cfg_rdata[31:24] == 8'h00;
  endproperty
  a_data_zero: assert property (p_data_zero) else $error("data byte not zero");

  property p_status_clear;
    @(posedge sys_clk) disable iff (!arst_n)
    wr_csr_hi && cfg_wdata[`FMPM_CSR_STAT_BIT] && !wake_event |=> !wake_status;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_status_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !wake_event && !(wr_csr_hi && cfg_wdata[`FMPM_CSR_STAT_BIT]) |=> $stable(wake_status);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status changed without cause");

  property p_enable_write;
    @(posedge sys_clk) disable iff (!arst_n)
    wr_csr_hi |=> wake_enable == $past(cfg_wdata[`FMPM_CSR_EN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not written");

  property p_enable_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !wr_csr_hi |=> $stable(wake_enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed without write");

  property p_level_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !wr_csr_lo |=> $stable(power_level);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("power level changed without write");

  property p_cold_write;
    @(posedge sys_clk) disable iff (!arst_n)
    wr_genctl |=> cold_state_wake_capable == $past(cfg_wdata[`FMPM_GENCTL_COLD_BIT]);
  endproperty
  a_cold_write: assert property (p_cold_write) else $error("cold wake bit not written");

  property p_cold_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !wr_genctl |=> $stable(cold_state_wake_capable);
  endproperty
  a_cold_hold: assert property (p_cold_hold) else $error("cold wake bit changed without write");

  property p_genctl_read;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_genctl_q |-> cfg_rdata == {27'h0000000, cold_q, 4'h0};
  endproperty
  a_genctl_read: assert property (p_genctl_read) else $error("general control read wrong");

  property p_wake_gate;
    @(posedge sys_clk) disable iff (!arst_n)
    wake_out |-> $past(wake_status) && $past(wake_enable);
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake output without cause");

  property p_func_reset_cause;
    @(posedge sys_clk) disable iff (!arst_n)
    func_reset |-> $past(wr_csr_lo) && $past(cfg_wdata[1:0]) == 2'h0 && $past(power_level) == fmpm_pkg::FMPM_D3HOT;
  endproperty
  a_func_reset_cause: assert property (p_func_reset_cause) else $error("internal reset without cause");

  property p_func_reset_pulse;
    @(posedge sys_clk) disable iff (!arst_n)
    func_reset |=> !func_reset;
  endproperty
  a_func_reset_pulse: assert property (p_func_reset_pulse) else $error("internal reset too long");

  c_wake: cover property (@(posedge sys_clk) disable iff (!arst_n) wake_out);
  c_func_reset: cover property (@(posedge sys_clk) disable iff (!arst_n) func_reset);
  c_status_clear: cover property (@(posedge sys_clk) disable iff (!arst_n) wake_status ##1 !wake_status);
  c_cold_caps: cover property (@(posedge sys_clk) disable iff (!arst_n) rd_caps_q && cfg_rdata[31]);
  c_wake_blocked: cover property (@(posedge sys_clk) disable iff (!arst_n) wake_status && !wake_enable);

endmodule // fmpm_regs_top
`default_nettype wire

// [src/fmpm_wake_ctl.sv]
// Wake status flag, wake enable and the gated wake output
`default_nettype none
module fmpm_wake_ctl (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wake_event,
  input wire logic status_clr,
  input wire logic enable_wr,
  input wire logic enable_val,
  output logic wake_status,
  output logic wake_enable,
  output logic wake_out
);

  // Of the resets, only the global reset clears these
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_status <= 1'b0;
    end else if (wake_event) begin
      wake_status <= 1'b1;
    end else if (status_clr) begin
      wake_status <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_enable <= 1'b0;
    end else if (enable_wr) begin
      wake_enable <= enable_val;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= wake_status & wake_enable;
    end
  end

endmodule // fmpm_wake_ctl
`default_nettype wire
